// file: include/prd_pkg.sv
// Package for the reference path, phase detector and lock indicator block
package prd_pkg;
   // Reference mode field encodings
   localparam logic [2:0] REF_MODE_XTAL_OFF = 3'h0;
   localparam logic [2:0] REF_MODE_XTAL_ON = 3'h1;
   localparam logic [2:0] REF_MODE_OUT_LOW = 3'h2;
   localparam logic [2:0] REF_MODE_DIV1 = 3'h3;
   localparam logic [2:0] REF_MODE_DIV2 = 3'h4;
   localparam logic [2:0] REF_MODE_DIV4 = 3'h5;
   localparam logic [2:0] REF_MODE_DIV8 = 3'h6;
   localparam logic [2:0] REF_MODE_DIV16 = 3'h7;
   localparam logic [2:0] REF_MODE_RESET = REF_MODE_DIV8;

   // AHB-Lite register map (byte addresses)
   localparam logic [7:0] ADDR_CONFIG = 8'h00;
   localparam logic [7:0] ADDR_REF_MODE = 8'h04;
   localparam logic [7:0] ADDR_STATUS = 8'h08;

   // Configuration register field positions
   localparam int CFG_CUR_STEP = 1;
   localparam int CFG_CUR_LO = 2;
   localparam int CFG_CUR_HI = 3;
   localparam int CFG_STANDBY = 4;
   localparam int CFG_LOCK_EN = 5;
   localparam int CFG_DET_SEL = 6;
   localparam int CFG_POLARITY = 7;
   localparam logic [7:0] CONFIG_RESET = 8'h00;

   // Status register field positions
   localparam int STS_VCO_UP = 0;
   localparam int STS_REF_UP = 1;
   localparam int STS_HOLD = 2;
   localparam int STS_OSC_ON = 3;

   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

   typedef enum logic [1:0] {
      PRD_RUN = 2'b00,
      PRD_STANDBY = 2'b01,
      PRD_WAIT_VCO = 2'b10
   } prd_state_t;

   typedef struct packed {
      logic [31:0] haddr;
      logic [1:0] htrans;
      logic hwrite;
      logic hsel;
      logic hready;
      logic [31:0] hwdata;
   } prd_ahb_in_t;

   typedef struct packed {
      logic [31:0] hrdata;
      logic hreadyout;
      logic hresp;
   } prd_ahb_out_t;

   typedef struct packed {
      logic reference_output;
      logic osc_enable;
      logic pd_sink;
      logic pd_source;
      logic pd_oe;
      logic [2:0] pd_current;
      logic vco_pulse_n;
      logic ref_pulse_n;
      logic lock_indicator;
   } prd_pins_t;
endpackage : prd_pkg

// file: verilog/prd_core.sv
// Reference mode control, phase/frequency detectors and lock indicator
`timescale 1ns/1ps
module prd_core
   import prd_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic reference_input,
   input wire logic divided_reference_pulse,
   input wire logic divided_vco_pulse,
   input wire prd_ahb_in_t ahb_in,
   output prd_ahb_out_t ahb_out,
   output prd_pins_t pins,
   output logic ref_counter_run,
   output logic ref_counter_jam
);

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed {
      prd_state_t state;
      logic [7:0] config_reg;
      logic [2:0] ref_mode;
      logic [2:0] sync_ref_in;
      logic [2:0] sync_ref_p;
      logic [2:0] sync_vco_p;
      logic ref_in_q;
      logic ref_p_q;
      logic vco_p_q;
      logic [3:0] div_count;
      logic ref_up;
      logic vco_up;
      logic ph_wr;
      logic [7:0] ph_addr;
      prd_ahb_out_t bus;
      prd_pins_t pins;
      logic run;
      logic jam;
   } prd_core_t;

   prd_core_t cur;
   prd_core_t next_cur;

   // Agreeing second and third stages form the filtered level
   function automatic logic filt(input logic [2:0] s, input logic prev);
      filt = (s[1] == s[2]) ? s[1] : prev;
   endfunction : filt

   logic ref_in_f;
   logic ref_p_f;
   logic vco_p_f;
   logic ref_edge;
   logic vco_edge;
   logic standby;
   logic det_sel;
   logic detector_polarity;
   logic gate_open;
   logic ref_rise;
   logic vco_rise;
   logic both_up;
   logic div_out;
   logic pd_active;
   logic pair_active;
   logic [31:0] rd_word;

   always_comb begin
      ref_in_f = filt(cur.sync_ref_in, cur.ref_in_q);
      ref_p_f = filt(cur.sync_ref_p, cur.ref_p_q);
      vco_p_f = filt(cur.sync_vco_p, cur.vco_p_q);
      ref_edge = ref_in_f & ~cur.ref_in_q;
      ref_rise = ref_p_f & ~cur.ref_p_q;
      vco_rise = vco_p_f & ~cur.vco_p_q;
      standby = cur.config_reg[CFG_STANDBY];
      det_sel = cur.config_reg[CFG_DET_SEL];
      detector_polarity = cur.config_reg[CFG_POLARITY];
      gate_open = (cur.state == PRD_RUN);
      both_up = cur.ref_up & cur.vco_up;
      pd_active = det_sel & ~standby & gate_open;
      pair_active = ~det_sel & ~standby & gate_open;
      unique case (cur.ref_mode)
         REF_MODE_DIV2: div_out = cur.div_count[0];
         REF_MODE_DIV4: div_out = cur.div_count[1];
         REF_MODE_DIV8: div_out = cur.div_count[2];
         REF_MODE_DIV16: div_out = cur.div_count[3];
         default: div_out = 1'b0;
      endcase
      rd_word = 32'h0000_0000;
      unique case (ahb_in.haddr[7:0])
         ADDR_CONFIG: rd_word[7:0] = cur.config_reg;
         ADDR_REF_MODE: rd_word[2:0] = cur.ref_mode;
         ADDR_STATUS: rd_word[3:0] = {cur.pins.osc_enable, ~gate_open, cur.ref_up, cur.vco_up};
         default: rd_word = 32'h0000_0000;
      endcase
   end

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb begin
      next_cur = cur;
      next_cur.sync_ref_in = {cur.sync_ref_in[1:0], reference_input};
      next_cur.sync_ref_p = {cur.sync_ref_p[1:0], divided_reference_pulse};
      next_cur.sync_vco_p = {cur.sync_vco_p[1:0], divided_vco_pulse};
      next_cur.ref_in_q = ref_in_f;
      next_cur.ref_p_q = ref_p_f;
      next_cur.vco_p_q = vco_p_f;

      // Zero wait states; reads return the value as it stands in the address phase
      next_cur.bus.hreadyout = 1'b1;
      next_cur.bus.hresp = 1'b0;
      next_cur.ph_wr = 1'b0;
      if (ahb_in.hsel && ahb_in.hready && ahb_in.htrans == HTRANS_NONSEQ) begin
         next_cur.ph_wr = ahb_in.hwrite;
         next_cur.ph_addr = ahb_in.haddr[7:0];
         next_cur.bus.hrdata = rd_word;
      end
      if (cur.ph_wr) begin
         unique case (cur.ph_addr)
            ADDR_CONFIG: next_cur.config_reg = ahb_in.hwdata[7:0];
            ADDR_REF_MODE: next_cur.ref_mode = ahb_in.hwdata[2:0];
            default: next_cur.ph_addr = cur.ph_addr;
         endcase
      end

      // standby exit waits for the first divided VCO pulse
      next_cur.jam = 1'b0;
      unique case (cur.state)
         PRD_RUN: if (standby) next_cur.state = PRD_STANDBY;
         PRD_STANDBY: if (!standby) next_cur.state = PRD_WAIT_VCO;
         PRD_WAIT_VCO: begin
            if (standby) begin
               next_cur.state = PRD_STANDBY;
            end else if (vco_rise) begin
               next_cur.state = PRD_RUN;
               next_cur.jam = 1'b1;
            end
         end
         default: next_cur.state = PRD_STANDBY;
      endcase

      // two state flops, cleared together once both are set
      // An edge that arrives in the clearing cycle still sets its flop, so none is lost
      if (!gate_open) begin
         next_cur.ref_up = 1'b0;
         next_cur.vco_up = 1'b0;
      end else begin
         next_cur.ref_up = (cur.ref_up & ~both_up) | ref_rise;
         next_cur.vco_up = (cur.vco_up & ~both_up) | vco_rise;
      end

      // divider on the filtered reference input
      if (ref_edge) next_cur.div_count = cur.div_count + 4'h1;

      // counter runs in every mode except REF_MODE_XTAL_OFF unless standby
      next_cur.run = ~standby & (cur.ref_mode != REF_MODE_XTAL_OFF);
      next_cur.pins.osc_enable = 1'b1;
      next_cur.pins.reference_output = 1'b0;
      unique case (cur.ref_mode)
         REF_MODE_XTAL_OFF: begin
            next_cur.pins.osc_enable = 1'b0;
            next_cur.run = 1'b0;
         end
         REF_MODE_XTAL_ON: next_cur.pins.reference_output = 1'b0;
         // reference path alive, output held low
         REF_MODE_OUT_LOW: next_cur.pins.reference_output = 1'b0;
         REF_MODE_DIV1: next_cur.pins.reference_output = ref_in_f;
         default: next_cur.pins.reference_output = div_out;
      endcase

      // sink on VCO lead, source on lag, inverted by polarity
      next_cur.pins.pd_sink = pd_active & ((cur.vco_up & ~cur.ref_up) ^ detector_polarity ? 1'b1 : 1'b0)
                              & (cur.vco_up ^ cur.ref_up);
      next_cur.pins.pd_source = pd_active & (cur.vco_up ^ cur.ref_up)
                                & ~((cur.vco_up & ~cur.ref_up) ^ detector_polarity);
      // float when deselected or in standby
      next_cur.pins.pd_oe = pd_active & (cur.vco_up ^ cur.ref_up);
      next_cur.pins.pd_current = {cur.config_reg[CFG_CUR_HI], cur.config_reg[CFG_CUR_LO],
                                  cur.config_reg[CFG_CUR_STEP]};
      // pulse pair, swapped by polarity, high when off
      next_cur.pins.vco_pulse_n = ~(pair_active & (detector_polarity ? cur.ref_up : cur.vco_up));
      next_cur.pins.ref_pulse_n = ~(pair_active & (detector_polarity ? cur.vco_up : cur.ref_up));
      // lock indicator gated by lock enable
      if (!cur.config_reg[CFG_LOCK_EN]) begin
         next_cur.pins.lock_indicator = 1'b0;
      end else if (standby) begin
         next_cur.pins.lock_indicator = 1'b1;
      end else begin
         next_cur.pins.lock_indicator = ~(pair_active | pd_active)
            | ~(cur.vco_up | cur.ref_up);
      end
   end

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cur <= '0;
         cur.state <= PRD_RUN;
         cur.ref_mode <= REF_MODE_RESET;
         cur.config_reg <= CONFIG_RESET;
         cur.bus.hreadyout <= 1'b1;
         cur.pins.vco_pulse_n <= 1'b1;
         cur.pins.ref_pulse_n <= 1'b1;
         cur.pins.osc_enable <= 1'b1;
      end else begin
         cur <= next_cur;
      end
   end

   assign ahb_out = cur.bus;
   assign pins = cur.pins;
   assign ref_counter_run = cur.run;
   assign ref_counter_jam = cur.jam;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   sequence lead_seq;
      cur.vco_up && !cur.ref_up && pd_active;
   endsequence

   pd_sink_dir_a: assert property (@(posedge clk) disable iff (rst)
      (lead_seq and !detector_polarity) |=> pins.pd_sink && !pins.pd_source)
      else $error("single-ended sink missing on VCO lead");
   pd_pol_inv_a: assert property (@(posedge clk) disable iff (rst)
      (lead_seq and detector_polarity) |=> pins.pd_source && !pins.pd_sink)
      else $error("single-ended polarity not inverted");
   pd_float_a: assert property (@(posedge clk) disable iff (rst)
      standby |=> !pins.pd_oe)
      else $error("single-ended output driven in standby");
   pd_desel_a: assert property (@(posedge clk) disable iff (rst)
      !det_sel |=> !pins.pd_oe)
      else $error("single-ended output driven while deselected");
   pair_rest_a: assert property (@(posedge clk) disable iff (rst)
      (standby || det_sel) |=> pins.vco_pulse_n && pins.ref_pulse_n)
      else $error("pulse pair not at rest");
   pair_swap_a: assert property (@(posedge clk) disable iff (rst)
      pair_active && detector_polarity && cur.vco_up && !cur.ref_up |=> !pins.ref_pulse_n && pins.vco_pulse_n)
      else $error("pulse pair not swapped");
   lock_off_a: assert property (@(posedge clk) disable iff (rst)
      !cur.config_reg[CFG_LOCK_EN] |=> !pins.lock_indicator)
      else $error("lock indicator not forced low");
   lock_and_a: assert property (@(posedge clk) disable iff (rst)
      cur.config_reg[CFG_LOCK_EN] && !standby && pair_active
      |=> pins.lock_indicator == (pins.vco_pulse_n & pins.ref_pulse_n))
      else $error("lock indicator differs from pulse pair AND");
   wake_block_a: assert property (@(posedge clk) disable iff (rst)
      cur.state == PRD_WAIT_VCO && !vco_rise && !standby |=> !cur.ref_up && !cur.vco_up)
      else $error("detector armed before first VCO pulse");
   xtal_off_a: assert property (@(posedge clk) disable iff (rst)
      cur.ref_mode == REF_MODE_XTAL_OFF |=> !pins.osc_enable)
      else $error("oscillator running in shut-down mode");
endmodule : prd_core

// file: verification/prd_loop_model.sv
// Behavioural reference source and divided loop pulse model
`timescale 1ns/1ps
module prd_loop_model (
   input wire logic clk,
   input wire logic rst,
   input wire logic [7:0] ref_per,
   input wire logic [7:0] vco_per,
   input wire logic align,
   output logic reference_input,
   output logic divided_reference_pulse,
   output logic divided_vco_pulse
);
   logic [7:0] rc;
   logic [7:0] vc;
   logic [1:0] tc;
   // Pulses last four cycles so the three-flop input filter keeps them
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         tc <= 2'h0;
         rc <= 8'h00;
         vc <= 8'h00;
         reference_input <= 1'b0;
         divided_reference_pulse <= 1'b0;
         divided_vco_pulse <= 1'b0;
      end else begin
         tc <= tc + 2'h1;
         reference_input <= (tc == 2'h3) ? ~reference_input : reference_input;
         rc <= (align || rc >= ref_per - 8'h01) ? 8'h00 : rc + 8'h01;
         vc <= (align || vc >= vco_per - 8'h01) ? 8'h00 : vc + 8'h01;
         divided_reference_pulse <= (rc + 8'h04 >= ref_per);
         divided_vco_pulse <= (vc + 8'h04 >= vco_per);
      end
   end
endmodule : prd_loop_model

// file: verification/test_prd_core.sv
// Self-checking testbench for the reference path, detectors and lock indicator
`timescale 1ns/1ps
module test_prd_core
   import prd_pkg::*;
;
   logic clk, rst, h_write, h_sel, per_align, ref_in, ref_p, vco_p, run, jam, ld_chk, prev_out;
   logic [1:0] h_trans;
   logic [31:0] h_addr, h_wdata, rdat;
   logic [7:0] ref_per, vco_per;
   prd_ahb_in_t bus_in;
   prd_ahb_out_t bus_out;
   prd_pins_t pins;
   int n_errors, total_checks, n_vlo, n_rlo, n_snk, n_src, n_oe, n_ldhi, n_ldbad;
   int n_rise, n_jam, n_run, n_osc;
   assign bus_in = '{h_addr, h_trans, h_write, h_sel, bus_out.hreadyout, h_wdata};
   prd_loop_model u_prd_loop_model (.clk(clk), .rst(rst), .ref_per(ref_per),
      .vco_per(vco_per), .align(per_align), .reference_input(ref_in),
      .divided_reference_pulse(ref_p), .divided_vco_pulse(vco_p));
   prd_core u_prd_core (.clk(clk), .rst(rst), .reference_input(ref_in),
      .divided_reference_pulse(ref_p), .divided_vco_pulse(vco_p), .ahb_in(bus_in),
      .ahb_out(bus_out), .pins(pins), .ref_counter_run(run), .ref_counter_jam(jam));
   // ------------------------------
   // Bus and measurement tasks
   // ------------------------------
   task close_out();
      $display("checks %0d errors %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : close_out
   task chk(input logic ok, input string msg);
      total_checks++;
      if (ok !== 1'b1) begin
         n_errors++;
         $display("Error at %0t: %s", $time, msg);
      end
   endtask : chk
   // Bounded wait: a slave that never answers ends the run
   task wait_rdy();
      int i;
      i = 0;
      @(posedge clk);
      while (bus_out.hreadyout !== 1'b1) begin
         i++;
         if (i > 20) begin
            chk(1'b0, "bus hang");
            close_out();
         end
         @(posedge clk);
      end
   endtask : wait_rdy
   task xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      h_sel <= 1'b1;
      h_trans <= HTRANS_NONSEQ;
      h_write <= wr;
      h_addr <= {24'h000000, a};
      wait_rdy();
      h_sel <= 1'b0;
      h_trans <= 2'h0;
      h_wdata <= d;
      wait_rdy();
      rdat = bus_out.hrdata;
   endtask : xfer
   // Margin covers the register update plus the registered pins
   task wr(input logic [7:0] a, input logic [31:0] d);
      xfer(1'b1, a, d);
      repeat (6) @(posedge clk);
   endtask : wr
   function automatic logic [31:0] cf(input logic p, input logic s, input logic l,
                                      input logic sb);
      return (32'(p) << CFG_POLARITY) | (32'(s) << CFG_DET_SEL) | (32'(l) << CFG_LOCK_EN)
         | (32'(sb) << CFG_STANDBY) | 32'h0000000A;
   endfunction : cf
   task realign(input logic [7:0] rp, input logic [7:0] vp);
      @(posedge clk);
      ref_per <= rp;
      vco_per <= vp;
      per_align <= 1'b1;
      @(posedge clk);
      per_align <= 1'b0;
   endtask : realign
   task run_cyc(input int n);
      {n_vlo, n_rlo, n_snk, n_src, n_oe, n_ldhi, n_ldbad, n_rise, n_jam, n_run, n_osc} = '0;
      repeat (n) begin
         @(negedge clk);
         n_vlo += (pins.vco_pulse_n === 1'b0);
         n_rlo += (pins.ref_pulse_n === 1'b0);
         n_oe += (pins.pd_oe === 1'b1);
         n_snk += (pins.pd_oe === 1'b1 && pins.pd_sink === 1'b1);
         n_src += (pins.pd_oe === 1'b1 && pins.pd_source === 1'b1);
         n_ldhi += (pins.lock_indicator === 1'b1);
         n_ldbad += (ld_chk && pins.lock_indicator !== (pins.vco_pulse_n & pins.ref_pulse_n));
         n_rise += (pins.reference_output === 1'b1 && prev_out === 1'b0);
         prev_out = pins.reference_output;
         n_jam += (jam === 1'b1);
         n_run += (run === 1'b1);
         n_osc += (pins.osc_enable === 1'b1);
      end
   endtask : run_cyc
   // ------------------------------
   // Scenarios
   // ------------------------------
   task t_reset();
      chk(pins.lock_indicator === 1'b0 && pins.pd_oe === 1'b0, "reset pins");
      xfer(1'b0, ADDR_REF_MODE, 32'h0);
      chk(rdat[2:0] === REF_MODE_RESET, "reset mode");
      xfer(1'b0, ADDR_CONFIG, 32'h0);
      chk(rdat[7:0] === CONFIG_RESET, "reset config");
      xfer(1'b1, 8'h0C, 32'hFFFFFFFF);
      xfer(1'b0, 8'h0C, 32'h0);
      chk(rdat === 32'h00000000, "unmapped read");
   endtask : t_reset
   task t_modes();
      for (int i = 0; i < 5; i++) begin
         wr(ADDR_REF_MODE, 32'(REF_MODE_DIV1) + 32'(i));
         run_cyc(1024);
         chk(n_rise >= (128 >> i) - 1 && n_rise <= (128 >> i) + 1, "divide ratio");
      end
      wr(ADDR_REF_MODE, 32'(REF_MODE_OUT_LOW));
      run_cyc(256);
      chk(n_rise == 0 && pins.reference_output === 1'b0, "output held");
   endtask : t_modes
   task t_xtal();
      wr(ADDR_REF_MODE, 32'(REF_MODE_XTAL_ON));
      run_cyc(16);
      chk(n_osc == 16 && n_run == 16, "crystal runs");
      wr(ADDR_CONFIG, cf(1'b0, 1'b0, 1'b0, 1'b1));
      run_cyc(16);
      chk(n_osc == 16 && n_run == 0, "counter halted");
      wr(ADDR_REF_MODE, 32'(REF_MODE_XTAL_OFF));
      run_cyc(16);
      chk(n_osc == 0, "osc stopped in standby");
      wr(ADDR_CONFIG, 32'h0);
      run_cyc(16);
      chk(n_osc == 0, "osc stopped");
      xfer(1'b0, ADDR_STATUS, 32'h0);
      chk(rdat[STS_OSC_ON] === 1'b0, "status osc off");
      wr(ADDR_REF_MODE, 32'(REF_MODE_DIV8));
   endtask : t_xtal
   task t_det();
      logic more;
      for (int f = 0; f < 2; f++) begin
         for (int k = 0; k < 4; k++) begin
            realign(8'h30, f ? 8'h38 : 8'h28);
            wr(ADDR_CONFIG, cf(k[0], k[1], 1'b1, 1'b0));
            ld_chk = !k[1];
            run_cyc(960);
            ld_chk = 1'b0;
            more = (f == 0) ^ k[0];
            if (k[1]) begin
               chk(pins.pd_current === 3'b101, "current level");
               chk(n_vlo == 0 && n_rlo == 0 && n_oe > 0, "pair parked");
               chk((n_snk > n_src) == more, "sink or source");
            end else begin
               chk(n_oe == 0 && n_ldbad == 0, "float and lock");
               chk((n_vlo > n_rlo) == more, "pulse side");
            end
         end
      end
   endtask : t_det
   task t_match();
      for (int s = 0; s < 2; s++) begin
         realign(8'h30, 8'h30);
         wr(ADDR_CONFIG, cf(1'b0, s[0], 1'b1, 1'b0));
         run_cyc(200);
         ld_chk = !s[0];
         run_cyc(960);
         ld_chk = 1'b0;
         chk(n_snk == n_src && n_vlo == n_rlo, "matched loop");
         chk(n_ldbad == 0 && (s[0] || n_ldhi > 900), "locked");
      end
   endtask : t_match
   task t_low_power_hold();
      for (int s = 0; s < 2; s++) begin
         wr(ADDR_CONFIG, cf(1'b0, s[0], 1'b1, 1'b1));
         run_cyc(100);
         chk(n_vlo == 0 && n_rlo == 0 && n_oe == 0, "standby outputs");
         chk(n_ldhi == 100, "lock static high");
      end
      // Lock indicator left disabled while unused
      wr(ADDR_CONFIG, cf(1'b0, 1'b0, 1'b0, 1'b1));
      run_cyc(100);
      chk(n_ldhi == 0, "lock static low");
   endtask : t_low_power_hold
   task t_wake();
      realign(8'hC8, 8'hC8);
      xfer(1'b1, ADDR_CONFIG, cf(1'b0, 1'b0, 1'b1, 1'b0));
      xfer(1'b0, ADDR_STATUS, 32'h0);
      chk(rdat[STS_HOLD] === 1'b1, "blocked after wake");
      run_cyc(300);
      chk(n_jam == 1, "one jam load");
      xfer(1'b0, ADDR_STATUS, 32'h0);
      chk(rdat[STS_HOLD] === 1'b0, "released");
   endtask : t_wake
   // ------------------------------
   // Clock, reset and sequence
   // ------------------------------
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   initial begin
      {h_write, h_sel, per_align, ld_chk, prev_out, h_trans, h_addr, h_wdata} = '0;
      rst = 1'b1;
      ref_per = 8'h30;
      vco_per = 8'h28;
      n_errors = 0;
      total_checks = 0;
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      t_reset();
      t_modes();
      t_xtal();
      t_det();
      t_match();
      t_low_power_hold();
      t_wake();
      close_out();
   end
endmodule : test_prd_core
